// *** bench/test_trigger_input_conditioning.sv ***
// testbench of the trigger conditioning top
`timescale 1ns/10ps
`include "tic_defs.vh"
module test_trigger_input_conditioning;
  localparam [31:0] tt = 32'h00961E78;
  reg clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, l2 = 0, ten = 0, lop = 0, go = 0;
  reg [3:0] adr = 4'h0;
  reg [3:0] sel = 4'hF, be = 4'hF;
  reg [5:0] cnt = 6'h0;
  reg [4:0] wid = 5'h1;
  reg [31:0] dat = 32'h0, q;
  wire [31:0] rd;
  wire ack, trig, nxt, outl, src, busy;
  integer err_total = 0, compares = 0, cycn = 0, pulses = 0, hi = 0, f, i;
  tic_top uut (.CLK_SYS(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rd), .WB_ACK_O(ack), .INPUT_LINE_FIRST(src),
    .INPUT_LINE_SECOND(l2), .TRIGGER_ENABLE(ten), .LOGIC_OPERAND_FIRST(lop), .CAMERA_TRIGGER(trig),
    .NEXT_OPERAND(nxt), .OUTPUT_LINE(outl));
  tic_src_model src_m (.clk(clk), .go(go), .cnt(cnt), .wid(wid), .line(src), .busy(busy));
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cycn = cycn + 1;
    if (trig === 1'b1) pulses = pulses + 1;
    if (outl === 1'b1) hi = hi + 1;
    if (cycn == 5000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= be;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rd; cyc <= 0; stb <= 0;
    end
  endtask
  task pulse(input [5:0] c, input [4:0] w);
    begin
      cnt <= c; wid <= w; go <= 1;
      @(posedge clk);
      go <= 0;
      @(posedge clk);
      while (busy) @(posedge clk);
      repeat (10) @(posedge clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1;
    bus(0, `TIC_ADR_CTRL, 32'h0); chk(q, `TIC_CTRL_RST);
    bus(0, `TIC_ADR_DEB, 32'h0); chk(q, `TIC_DEB_RST);
    bus(1, 4'hC, 32'hFFFF); bus(0, 4'hC, 32'h0); chk(q, 32'h0);
    bus(1, `TIC_ADR_DEB, 32'h5); bus(0, `TIC_ADR_DEB, 32'h0); chk(q, 32'h5);
    be <= 4'h2; bus(1, `TIC_ADR_CTRL, 32'hFFFF0AFF); be <= 4'hF;
    bus(0, `TIC_ADR_CTRL, 32'h0); chk(q, 32'h00000A00);
    $display("registers done");
    for (f = 0; f < 8; f = f + 1) begin
      bus(1, `TIC_ADR_CTRL, 32'hD0 | f);
      for (i = 0; i < 4; i = i + 1) begin
        lop <= i[1]; l2 <= i[0];
        repeat (3) @(posedge clk);
        chk({30'h0, nxt, outl}, {30'h0, tt[f*4+i], tt[f*4+i]});
      end
    end
    bus(1, `TIC_ADR_CTRL, 32'h98);
    lop <= 1; l2 <= 0; ten <= 1; repeat (3) @(posedge clk);
    chk({30'h0, nxt, outl}, 32'h1);
    ten <= 0; l2 <= 1; repeat (3) @(posedge clk);
    chk({30'h0, nxt, outl}, 32'h0);
    bus(1, `TIC_ADR_CTRL, 32'h58); ten <= 1; repeat (3) @(posedge clk);
    chk({30'h0, nxt, outl}, 32'h2);
    $display("logic done");
    bus(1, `TIC_ADR_CTRL, 32'hA2); l2 <= 0;
    for (i = 4; i < 6; i = i + 1) begin
      hi = 0; pulse(1, i); chk(hi, (i == 5) ? 5 : 0);
    end
    bus(1, `TIC_ADR_CTRL, 32'h82); hi = 0; pulse(1, 2); chk(hi, 2);
    $display("debounce done");
    chk(pulses, 0);
    for (f = 0; f < 16; f = f + 5) begin
      pulses = 0; bus(1, `TIC_ADR_CTRL, 32'h1002 | (f << 8)); pulse(2 * f + 2, 2); chk(pulses, 2);
    end
    pulses = 0; bus(1, `TIC_ADR_CTRL, 32'h1102); pulse(1, 2);
    bus(1, `TIC_ADR_CTRL, 32'h1202); pulse(2, 2); chk(pulses, 0);
    bus(0, `TIC_ADR_STAT, 32'h0); chk(q, 32'h00000020);
    $display("prescale done");
    tally_and_finish;
  end
endmodule // test_trigger_input_conditioning
bind tic_top tic_top_monitor mon (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .CAMERA_TRIGGER(CAMERA_TRIGGER), .NEXT_OPERAND(NEXT_OPERAND), .OUTPUT_LINE(OUTPUT_LINE));

// *** bench/tic_src_model.sv ***
// behavioural switch or sensor driving the first input line
`timescale 1ns/10ps
module tic_src_model (
  input wire clk,
  input wire go,
  input wire [5:0] cnt,
  input wire [4:0] wid,
  output reg line,
  output reg busy
);
  initial begin
    line = 1'h0;
    busy = 1'h0;
  end
  always @(posedge clk) begin
    if (go) begin
      busy <= 1'h1;
      repeat (cnt) begin
        line <= 1'h1;
        repeat (wid) @(posedge clk);
        line <= 1'h0;
        repeat (wid) @(posedge clk);
      end
      busy <= 1'h0;
    end
  end
endmodule // tic_src_model

// *** bench/tic_top_monitor.sv ***
// assertion checker for the trigger conditioning top
`timescale 1ns/10ps
module tic_top_monitor (
  input wire CLK_SYS,
  input wire RST_B,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [3:0] WB_ADR_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire CAMERA_TRIGGER,
  input wire NEXT_OPERAND,
  input wire OUTPUT_LINE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  chk_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  chk_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  chk_ack_needs_req: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without request");
  chk_ack_rose_req: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack rose alone");
  chk_ack_shape: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |-> ##1 WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack shape");
  chk_unmapped_zero: assert property (WB_CYC_I && WB_STB_I && !WB_WE_I && WB_ADR_I > 4'h8 |=> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  chk_trig_pulse:
    assert property (CAMERA_TRIGGER |=> !CAMERA_TRIGGER) else $error("trigger not a pulse");
  chk_reset_quiet: assert property ($rose(RST_B) |-> !CAMERA_TRIGGER && !NEXT_OPERAND && !OUTPUT_LINE)
    else $error("outputs busy after reset");
endmodule // tic_top_monitor

// *** include/tic_defs.vh ***
// constants of the trigger input conditioning block
`ifndef TIC_DEFS_VH
`define TIC_DEFS_VH
`define TIC_ADR_CTRL 4'h0
`define TIC_ADR_DEB 4'h4
`define TIC_ADR_STAT 4'h8
`define TIC_CTRL_FUNC_LSB 0
`define TIC_CTRL_TEN_BIT 3
`define TIC_CTRL_SRC_BIT 4
`define TIC_CTRL_DEBEN_BIT 5
`define TIC_CTRL_ROUTE_LSB 6
`define TIC_CTRL_DIV_LSB 8
`define TIC_CTRL_TRGEN_BIT 12
`define TIC_CTRL_RST 32'h00000000
`define TIC_CTRL_WMASK 32'h00001FFF
`define TIC_ROUTE_TRIG 2'h0
`define TIC_ROUTE_NEXT 2'h1
`define TIC_ROUTE_OUT 2'h2
`define TIC_ROUTE_ALL 2'h3
`define TIC_DEB_RST 32'h00000000
`define TIC_FN_AND 3'h0
`define TIC_FN_NAND 3'h1
`define TIC_FN_OR 3'h2
`define TIC_FN_NOR 3'h3
`define TIC_FN_XOR 3'h4
`define TIC_FN_XNOR 3'h5
`define TIC_TIC_PS 15000
`define TIC_CLK_PS 8000
`endif

// *** rtl/tic_debounce.v ***
// debouncer for one input level
`timescale 1ns/10ps
module tic_debounce (
  input wire clk,
  input wire rst_b,
  input wire din,
  input wire [31:0] length,
  output reg dout
);
  reg [31:0] cnt_reg;
  // ----------------------------------------
  // stability counter
  // ----------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 32'h00000000;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_reg <= 32'h00000000;
    end else if (cnt_reg + 32'h00000001 >= length) begin
      cnt_reg <= 32'h00000000;
      dout <= din;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001;
    end
  end
endmodule // tic_debounce

// *** rtl/tic_top.v ***
// trigger input conditioning top with wishbone registers
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/10ps
`include "tic_defs.vh"
module tic_top (
  CLK_SYS,
  RST_B,
  WB_CYC_I,
  WB_STB_I,
  WB_WE_I,
  WB_ADR_I,
  WB_SEL_I,
  WB_DAT_I,
  WB_DAT_O,
  WB_ACK_O,
  INPUT_LINE_FIRST,
  INPUT_LINE_SECOND,
  TRIGGER_ENABLE,
  LOGIC_OPERAND_FIRST,
  CAMERA_TRIGGER,
  NEXT_OPERAND,
  OUTPUT_LINE
);
  input wire CLK_SYS;
  input wire RST_B;
  input wire WB_CYC_I;
  input wire WB_STB_I;
  input wire WB_WE_I;
  input wire [3:0] WB_ADR_I;
  input wire [3:0] WB_SEL_I;
  input wire [31:0] WB_DAT_I;
  output reg [31:0] WB_DAT_O;
  output reg WB_ACK_O;
  input wire INPUT_LINE_FIRST;
  input wire INPUT_LINE_SECOND;
  input wire TRIGGER_ENABLE;
  input wire LOGIC_OPERAND_FIRST;
  output reg CAMERA_TRIGGER;
  output reg NEXT_OPERAND;
  output reg OUTPUT_LINE;

  reg [31:0] ctrl_reg;
  reg [31:0] deb_reg;
  reg [3:0] pcnt_reg;
  reg [3:0] div_last_reg;
  reg trig_last_reg;
  reg logic_y;
  wire [2:0] func;
  wire [3:0] div;
  wire [1:0] route;
  wire deb_out;
  wire cond_in;
  wire operand_first;
  wire operand_second;
  wire wr_req;
  wire rise;
  reg [3:0] pcnt_next;
  reg cam_next;
  reg ack_next;
  reg [31:0] rdata_next;
  wire wr_ctrl;
  wire wr_deb;

  // ----------------------------------------
  // byte lane merge
  // ----------------------------------------
  function [31:0] merge;
    input [31:0] old;
    input [31:0] new_data;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = new_data[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // route decode, route 3 drives every sink
  // ----------------------------------------
  function route_has;
    input [1:0] route_code;
    input [1:0] sink;
    begin
      route_has = (route_code == sink) || (route_code == `TIC_ROUTE_ALL);
    end
  endfunction

  // ----------------------------------------
  // boolean function of two operands
  // ----------------------------------------
  function logic_eval;
    input [2:0] fn;
    input op_a;
    input op_b;
    begin
      case (fn)
        `TIC_FN_AND: logic_eval = op_a & op_b;
        `TIC_FN_NAND: logic_eval = ~(op_a & op_b);
        `TIC_FN_OR: logic_eval = op_a | op_b;
        `TIC_FN_NOR: logic_eval = ~(op_a | op_b);
        `TIC_FN_XOR: logic_eval = op_a ^ op_b;
        `TIC_FN_XNOR: logic_eval = ~(op_a ^ op_b);
        default: logic_eval = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // control fields and write decode
  // ----------------------------------------
  assign func = ctrl_reg[`TIC_CTRL_FUNC_LSB +: 3];
  assign div = ctrl_reg[`TIC_CTRL_DIV_LSB +: 4];
  assign route = ctrl_reg[`TIC_CTRL_ROUTE_LSB +: 2];
  assign wr_req = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O; // write lands on the acknowledged edge
  assign wr_ctrl = wr_req & (WB_ADR_I == `TIC_ADR_CTRL);
  assign wr_deb = wr_req & (WB_ADR_I == `TIC_ADR_DEB);

  // ----------------------------------------
  // wishbone slave, one wait cycle
  // ----------------------------------------
  always @* begin
    ack_next = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    case (WB_ADR_I)
      `TIC_ADR_CTRL: begin
        rdata_next = ctrl_reg;
      end
      `TIC_ADR_DEB: begin
        rdata_next = deb_reg;
      end
      `TIC_ADR_STAT: begin
        rdata_next = {24'h000000, pcnt_reg, 1'b0, deb_out, logic_y, CAMERA_TRIGGER};
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg <= `TIC_CTRL_RST;
      deb_reg <= `TIC_DEB_RST;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= ack_next;
      WB_DAT_O <= rdata_next;
      if (wr_ctrl) begin
        ctrl_reg <= merge(ctrl_reg, WB_DAT_I, WB_SEL_I) & `TIC_CTRL_WMASK;
      end
      if (wr_deb) begin
        deb_reg <= merge(deb_reg, WB_DAT_I, WB_SEL_I);
      end
    end
  end

  // ----------------------------------------
  // debouncer and bypass
  // ----------------------------------------
  tic_debounce u_deb (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .din(INPUT_LINE_FIRST),
    .length(deb_reg),
    .dout(deb_out)
  );

  // ----------------------------------------
  // operand select
  // ----------------------------------------
  assign cond_in = ctrl_reg[`TIC_CTRL_DEBEN_BIT] ? deb_out : INPUT_LINE_FIRST;
  assign operand_first = ctrl_reg[`TIC_CTRL_SRC_BIT] ? LOGIC_OPERAND_FIRST : cond_in;
  assign operand_second = ctrl_reg[`TIC_CTRL_TEN_BIT] ? TRIGGER_ENABLE : INPUT_LINE_SECOND;

  // ----------------------------------------
  // logic stage
  // ----------------------------------------
  always @* begin
    logic_y = logic_eval(func, operand_first, operand_second);
  end

  // ----------------------------------------
  // prescaler next state
  // ----------------------------------------
  assign rise = logic_y & ~trig_last_reg;
  always @* begin
    pcnt_next = pcnt_reg;
    cam_next = 1'b0;
    if (div != div_last_reg) begin
      pcnt_next = 4'h0;
    end else if (rise && ctrl_reg[`TIC_CTRL_TRGEN_BIT]) begin
      if (pcnt_reg == div) begin
        pcnt_next = 4'h0;
        cam_next = route_has(route, `TIC_ROUTE_TRIG);
      end else begin
        pcnt_next = pcnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // output registers and routing
  // ----------------------------------------
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      pcnt_reg <= 4'h0;
      div_last_reg <= 4'h0;
      trig_last_reg <= 1'b0;
      CAMERA_TRIGGER <= 1'b0;
      NEXT_OPERAND <= 1'b0;
      OUTPUT_LINE <= 1'b0;
    end else begin
      trig_last_reg <= logic_y;
      div_last_reg <= div;
      pcnt_reg <= pcnt_next;
      CAMERA_TRIGGER <= cam_next;
      NEXT_OPERAND <= logic_y & route_has(route, `TIC_ROUTE_NEXT);
      OUTPUT_LINE <= logic_y & route_has(route, `TIC_ROUTE_OUT);
    end
  end
endmodule // tic_top
